// >>> dv/lane_cfg_checker_assertions.sv
// Port-level assertions for the lane path and configuration block
`timescale 1ns/1ps
`default_nettype none
module lane_cfg_checker
	import lane_cfg_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic BUS_CONFIG_MODE_PIN,
	input wire logic [1:0] PORT_A_INPUT_BOOST_STRAP,
	input wire logic [1:0] IDLE_CONTROL_STRAPS,
	input wire logic BROADCAST_ENABLE,
	input wire logic LANE0_PATH_SELECT,
	input wire logic LANE1_PATH_SELECT,
	input wire logic [1:0] HOST_IN_LANE,
	input wire logic [1:0] PORT_A_IN_LANE,
	input wire logic [1:0] PORT_B_IN_LANE,
	input wire logic [1:0] HOST_OUT_LANE,
	input wire logic [1:0] PORT_A_OUT_LANE,
	input wire logic [1:0] PORT_B_OUT_LANE,
	input wire lane_cfg_s PORT_A_CFG,
	input wire logic [6:0] SLAVE_ADDRESS,
	input wire logic BUS_READY
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// Lane selects and the broadcast mask
	wire logic [1:0] sel = {LANE1_PATH_SELECT, LANE0_PATH_SELECT};
	wire logic [1:0] bc2 = {2{BROADCAST_ENABLE}};
	wire logic [1:0] h_exp = (sel & PORT_A_IN_LANE) | (~sel & PORT_B_IN_LANE);
	logic [15:0] por_cnt; // Cycles since reset release
	// Pin mode, idle pass-through, control pins steady past the syncs
	sequence quiet;
		(!BUS_CONFIG_MODE_PIN && IDLE_CONTROL_STRAPS == 2'h0 &&
		$stable({sel, bc2, PORT_A_INPUT_BOOST_STRAP}))[*4];
	endsequence
	// Counts up after reset and saturates
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			por_cnt <= 16'h0;
		else if (por_cnt != 16'hFFFF)
			por_cnt <= por_cnt + 16'h1;
	end
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack one cycle after request");
	a_host_route: assert property (quiet |-> HOST_OUT_LANE == h_exp)
		else $error("host output from wrong port");
	a_port_a_drive: assert property
		(quiet |-> PORT_A_OUT_LANE == (HOST_IN_LANE & (sel | bc2)))
		else $error("port A output wrong");
	a_port_b_drive: assert property
		(quiet |-> PORT_B_OUT_LANE == (HOST_IN_LANE & (~sel | bc2)))
		else $error("port B output wrong");
	a_boost_pins: assert property (quiet |-> PORT_A_CFG.boost ==
		(PORT_A_INPUT_BOOST_STRAP == 2'h0 ? BOOST_9DB :
		PORT_A_INPUT_BOOST_STRAP == 2'h1 ? BOOST_13P5DB : BOOST_18P4DB))
		else $error("boost decode wrong");
	a_idle_force: assert property
		((!BUS_CONFIG_MODE_PIN && IDLE_CONTROL_STRAPS == 2'h3)[*4]
		|-> PORT_A_CFG.idle == IDLE_FORCE)
		else $error("idle not forced");
	a_bus_defaults: assert property ($rose(BUS_CONFIG_MODE_PIN) ##1
		BUS_CONFIG_MODE_PIN[*3] |-> PORT_A_CFG.boost == BOOST_9DB)
		else $error("bus mode not on default registers");
	a_pin_addr: assert property
		((!BUS_CONFIG_MODE_PIN)[*4] |-> SLAVE_ADDRESS == 7'h50)
		else $error("address moved in pin mode");
	a_ready_bound: assert property (por_cnt > 16'h4E25 |-> BUS_READY)
		else $error("bus not ready in time");
endmodule : lane_cfg_checker
bind lane_path_select_and_config_decode lane_cfg_checker u_lane_cfg_checker (.*);
`default_nettype wire

// >>> dv/strap_board.sv
// Board strapping model: chosen levels to comparator bit pairs
`timescale 1ns/1ps
`default_nettype none
module strap_board
	import lane_cfg_pkg::*;
(
	input wire level_e [7:0] lvl,
	output logic [7:0][1:0] pin
);
	// Each strap reads {high, not low}; floating sits mid-rail
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin[i] = {lvl[i] == LVL_HIGH, lvl[i] != LVL_LOW};
		end
	end
endmodule : strap_board
`default_nettype wire

// >>> dv/test_lane_path_select_and_config_decode.sv
// Self-checking bench of the lane path and configuration block
`timescale 1ns/1ps
`default_nettype none
module test_lane_path_select_and_config_decode
	import lane_cfg_pkg::*;
;
	logic CLOCK, RST_N, cyc, stb, we, mode, bc, s0, s1, d6;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic [1:0] hin, ain, bin;
	logic [1:0] thr; // Idle detector outputs per lane
	level_e [7:0] lv; // Strap levels: A/B/host boost, A/B/host emph, rate, idle
	logic [7:0][1:0] pin;
	wire logic [31:0] rdat;
	wire logic ack, rdy;
	wire logic [1:0] hout, aout, bout;
	wire logic [6:0] saddr;
	lane_cfg_s acfg, bcfg;
	lane_cfg_s [1:0] hcfg;
	int failures = 0;
	int samples_checked = 0;
	strap_board u_strap_board (.lvl(lv), .pin(pin));
	lane_path_select_and_config_decode u_lane_path_select_and_config_decode (
		.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .BUS_CONFIG_MODE_PIN(mode),
		.PORT_A_INPUT_BOOST_STRAP(pin[0]), .PORT_B_INPUT_BOOST_STRAP(pin[1]),
		.HOST_INPUT_BOOST_STRAP(pin[2]), .PORT_A_OUTPUT_EMPH_STRAP(pin[3]),
		.PORT_B_OUTPUT_EMPH_STRAP(pin[4]), .HOST_OUTPUT_EMPH_STRAP(pin[5]),
		.RATE_STRAP(pin[6]), .IDLE_CONTROL_STRAPS(pin[7]),
		.BROADCAST_ENABLE(bc), .LANE0_PATH_SELECT(s0), .LANE1_PATH_SELECT(s1),
		.DETECTED_6G(d6), .BUS_CLOCK_IN(1'b1), .HOST_IN_LANE(hin),
		.PORT_A_IN_LANE(ain), .PORT_B_IN_LANE(bin), .INPUT_BELOW_THRESHOLD(thr),
		.HOST_OUT_LANE(hout), .PORT_A_OUT_LANE(aout), .PORT_B_OUT_LANE(bout),
		.PORT_A_CFG(acfg), .PORT_B_CFG(bcfg), .HOST_LANE_CFG(hcfg),
		.SLAVE_ADDRESS(saddr), .BUS_TIMEOUT(), .BUS_READY(rdy));
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : wt
	// One classic Wishbone cycle, data taken at the ack edge
	task automatic wb(input logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge CLOCK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge CLOCK);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			failures++;
			$display("ERROR wb ack expected 1 seen %b", ack);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	function automatic boost_e bst(input level_e l);
		return l == LVL_LOW ? BOOST_9DB : l == LVL_FLOAT ? BOOST_13P5DB :
			BOOST_18P4DB;
	endfunction : bst
	// All eight select and broadcast combinations
	task automatic t_route;
		for (int i = 0; i < 8; i++) begin
			@(posedge CLOCK);
			{bc, s1, s0} <= i[2:0];
			hin <= 2'h3;
			ain <= i[1:0];
			bin <= ~i[1:0];
			wt(4);
			chk("host out", {s1 ? ain[1] : bin[1], s0 ? ain[0] : bin[0]}, hout);
			chk("port a out", hin & ({s1, s0} | {2{bc}}), aout);
			chk("port b out", hin & (~{s1, s0} | {2{bc}}), bout);
		end
	endtask : t_route
	// Each side decoded from its own strap
	task automatic t_boost;
		for (int i = 0; i < 3; i++) begin
			@(posedge CLOCK);
			lv[0] <= level_e'(i);
			lv[1] <= level_e'((i + 1) % 3);
			lv[2] <= level_e'((i + 2) % 3);
			wt(4);
			chk("a boost", bst(lv[0]), acfg.boost);
			chk("b boost", bst(lv[1]), bcfg.boost);
			chk("host boost", bst(lv[2]), hcfg[0].boost);
			chk("host1 boost", bst(lv[2]), hcfg[1].boost);
		end
	endtask : t_boost
	// Emphasis level, width and swing over rate and detected rate
	task automatic t_emph;
		level_e e;
		logic f;
		emph_e ee;
		pulse_e pe;
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 6; k++) begin
				e = level_e'(k % 3);
				f = r == 2 || (r == 1 && k > 2);
				ee = e == LVL_LOW ? EMPH_3P5DB : e == LVL_HIGH ? EMPH_6DB :
					f ? EMPH_12DB : EMPH_9DB;
				pe = e == LVL_FLOAT ? (f ? PW_160PS : PW_250PS) :
					(f ? PW_200PS : PW_330PS);
				@(posedge CLOCK);
				lv[6] <= level_e'(r);
				lv[3] <= e;
				d6 <= k > 2;
				wt(4);
				chk("a emph", ee, acfg.emph);
				chk("a pulse", pe, acfg.pulse);
				chk("a swing up", 1, acfg.swing !== SWING_NOMINAL);
				if (e == LVL_FLOAT)
					chk("a swing", SWING_1200MV, acfg.swing);
			end
		end
	endtask : t_emph
	// Idle strap levels
	task automatic t_idle;
		for (int i = 0; i < 4; i++) begin
			@(posedge CLOCK);
			lv[7] <= level_e'(i % 3);
			wt(4);
			chk("a idle", i % 3 == 0 ? IDLE_PASS : i == 1 ? IDLE_AUTO :
				IDLE_FORCE, acfg.idle);
			if (i == 1) begin
				thr <= 2'h3;
				wt(1);
				chk("auto mute host", 2'h0, hout);
				chk("auto mute port a", 2'h0, aout);
				thr <= 2'h0;
			end
			if (i == 2)
				chk("forced idle", 6'h0, {hout, aout, bout});
		end
	endtask : t_idle
	// Bus mode entry, per-lane registers, pin override and exit
	task automatic t_bus;
		logic [31:0] q;
		@(posedge CLOCK);
		lv[0] <= LVL_HIGH;
		{bc, s1, s0} <= 3'h1;
		wb(1'b1, 8'h04, 32'h22, q);
		@(posedge CLOCK);
		mode <= 1'b1;
		wt(4);
		chk("bus boost", BOOST_9DB, acfg.boost);
		chk("addr top", 3'h5, saddr[6:4]);
		chk("pin sel", ain[0], hout[0]);
		wb(1'b0, 8'h04, 32'h0, q);
		chk("pin mode write", 32'h0, q);
		wb(1'b1, 8'h04, 32'h22, q);
		wb(1'b0, 8'h04, 32'h0, q);
		chk("lane a read", 32'h22, q);
		chk("lane a boost", BOOST_18P4DB, acfg.boost);
		chk("lane b boost", BOOST_9DB, bcfg.boost);
		wb(1'b0, 8'hFC, 32'h0, q);
		chk("unmapped read", 32'h0, q);
		wb(1'b1, 8'h00, 32'h0, q);
		wt(2);
		chk("reg sel", bin[0], hout[0]);
		mode <= 1'b0;
		wt(4);
		chk("pin sel back", ain[0], hout[0]);
		mode <= 1'b1;
		wt(4);
		wb(1'b0, 8'h04, 32'h0, q);
		chk("lane a cleared", 32'h0, q);
	endtask : t_bus
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Clock at 40 MHz
	initial begin
		CLOCK = 1'b0;
		forever #12.5 CLOCK = ~CLOCK;
	end
	// Watchdog well past the expected run
	initial begin
		wt(60000);
		failures++;
		$display("ERROR watchdog expected done seen hang");
		end_sim();
	end
	// Main sequence
	initial begin
		int n = 0;
		{RST_N, cyc, stb, we, mode, bc, s0, s1, d6} = 9'h0;
		{adr, wdat, hin, ain, bin} = 46'h0;
		thr = 2'h0;
		foreach (lv[i])
			lv[i] = LVL_LOW;
		wt(2);
		RST_N <= 1'b1;
		while (rdy !== 1'b1 && n < 30000) begin
			@(posedge CLOCK);
			n++;
		end
		chk("bus ready", 1, rdy);
		t_route();
		t_boost();
		t_emph();
		t_idle();
		t_bus();
		end_sim();
	end
endmodule : test_lane_path_select_and_config_decode
`default_nettype wire

// >>> inc/lane_cfg_map.svh
// Offsets, field positions, reset values and timing counts of the lane block
`ifndef LANE_CFG_MAP_SVH
`define LANE_CFG_MAP_SVH
// Register byte addresses (one aligned word each)
`define REG_CTRL 8'h00
`define REG_LANE0 8'h04
`define REG_LANE1 8'h08
// Status and address words sit above the six lane words, so that every
// lane end, host lane 0 included, has an address of its own
`define REG_STATUS 8'h1C
`define REG_ADDR 8'h20
// Control register fields
`define CTRL_SOFT_RESET 0
`define CTRL_PATH0 1
`define CTRL_PATH1 2
`define CTRL_BCAST 3
`define CTRL_RATE_LO 4
`define CTRL_IDLE_LO 6
// Lane register fields: boost [1:0], emph [3:2], swing [5:4], idle [7:6]
`define LANE_BOOST_LO 0
`define LANE_EMPH_LO 2
`define LANE_SWING_LO 4
`define LANE_IDLE_LO 6
`define LANE_RESET 8'h00
`define CTRL_RESET 8'h00
// Timing (ms) and derived counts at 40 MHz
`define CLK_KHZ 40000
`define TIMEOUT_MS 25
`define TIMEOUT_CYC (`TIMEOUT_MS * `CLK_KHZ)
`define STRETCH_MS 2
`define STRETCH_CYC (`STRETCH_MS * `CLK_KHZ)
`define POR_MS 500
`define POR_CYC (`POR_MS * `CLK_KHZ)
`endif

// >>> inc/lane_cfg_pkg.sv
// Types shared by the lane path and configuration block
package lane_cfg_pkg;
	// Three-level pin state, floating kept as its own code
	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_FLOAT = 2'h1,
		LVL_HIGH = 2'h2
	} level_e;
	// Boost choice: 9, 13.5, 18.4 dB at 3 GHz
	typedef enum logic [1:0] {
		BOOST_9DB = 2'h0,
		BOOST_13P5DB = 2'h1,
		BOOST_18P4DB = 2'h2
	} boost_e;
	// De-emphasis choice
	typedef enum logic [2:0] {
		EMPH_OFF = 3'h0,
		EMPH_3P5DB = 3'h1,
		EMPH_6DB = 3'h2,
		EMPH_9DB = 3'h3,
		EMPH_12DB = 3'h4
	} emph_e;
	// Pulse width choice
	typedef enum logic [1:0] {
		PW_330PS = 2'h0,
		PW_200PS = 2'h1,
		PW_250PS = 2'h2,
		PW_160PS = 2'h3
	} pulse_e;
	// Output swing choice
	typedef enum logic [1:0] {
		SWING_NOMINAL = 2'h0,
		SWING_1000MV = 2'h1,
		SWING_1200MV = 2'h2
	} swing_e;
	// Idle handling
	typedef enum logic [1:0] {
		IDLE_PASS = 2'h0,
		IDLE_AUTO = 2'h1,
		IDLE_FORCE = 2'h2
	} idle_e;
	// Settings of one output driver or input stage
	typedef struct packed {
		boost_e boost;
		emph_e emph;
		pulse_e pulse;
		swing_e swing;
		idle_e idle;
	} lane_cfg_s;
	// Configuration mode: straps or bus registers
	typedef enum logic [1:0] {
		MODE_STRAP = 2'h1,
		MODE_BUS = 2'h2
	} mode_e;
endpackage : lane_cfg_pkg

// >>> rtl/lane_path_select_and_config_decode.sv
// Lane path selection and pin or register configuration decode
`timescale 1ns/1ps
`default_nettype none
`include "lane_cfg_map.svh"

// What this block does
// - Bus-mode pin picks straps or registers
// - Straps configure each port side separately
// - Active emphasis raises swing per decode
// - Auto rate uses detected rate entries
// - Bus mode holds settings per lane
// - Bus mode switches to registers immediately
// - Bus mode turns straps into address
// - Control pins rule until register written
// - Power-up or bus mode low resets registers
// - Boost strap low/float/high: 9/13.5/18.4 dB
// - Emph low -3.5, high -6; 330/200 ps
// - Emph float: enhanced -9/-12 dB, 1200 mV
// - Idle strap low: detector off, pass through
// - Idle strap float: auto idle below threshold
// - Idle strap high: output always idle
// - Select low routes lane to port B
// - Select high routes lane to port A
// - Bus clock low 25 ms is timeout
// - Never stretch bus clock beyond 2 ms
// - Bus ready within 500 ms of power-on
// - Broadcast drives both ports from host
module lane_path_select_and_config_decode
	import lane_cfg_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	// Classic Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Pins, each three-level strap as a high/low pair of comparator bits
	input wire logic BUS_CONFIG_MODE_PIN,
	input wire logic [1:0] PORT_A_INPUT_BOOST_STRAP,
	input wire logic [1:0] PORT_B_INPUT_BOOST_STRAP,
	input wire logic [1:0] HOST_INPUT_BOOST_STRAP,
	input wire logic [1:0] PORT_A_OUTPUT_EMPH_STRAP,
	input wire logic [1:0] PORT_B_OUTPUT_EMPH_STRAP,
	input wire logic [1:0] HOST_OUTPUT_EMPH_STRAP,
	input wire logic [1:0] RATE_STRAP,
	input wire logic [1:0] IDLE_CONTROL_STRAPS,
	input wire logic BROADCAST_ENABLE,
	input wire logic LANE0_PATH_SELECT,
	input wire logic LANE1_PATH_SELECT,
	input wire logic DETECTED_6G,
	input wire logic BUS_CLOCK_IN,
	input wire logic [1:0] HOST_IN_LANE,
	input wire logic [1:0] PORT_A_IN_LANE,
	input wire logic [1:0] PORT_B_IN_LANE,
	input wire logic [1:0] INPUT_BELOW_THRESHOLD,
	// Data path controls
	output logic [1:0] HOST_OUT_LANE,
	output logic [1:0] PORT_A_OUT_LANE,
	output logic [1:0] PORT_B_OUT_LANE,
	output lane_cfg_s PORT_A_CFG,
	output lane_cfg_s PORT_B_CFG,
	output lane_cfg_s [1:0] HOST_LANE_CFG,
	output logic [6:0] SLAVE_ADDRESS,
	output logic BUS_TIMEOUT,
	output logic BUS_READY
);

	// Pin synchronisers: first stage read only by the second
	// Every strap, select and rate detector pin is asynchronous to CLOCK, so all
	// of them pass the same two stages and stay aligned with each other.
	// The vector holds exactly one bit per pin bit: a spare bit here would
	// shift every field and leave the mode bit stuck low.
	// The stages carry no reset; two clocks after reset release they hold
	// the real pin levels, which is why the bench waits before checking.
	logic [21:0] pin_meta; // First stage, may be metastable
	logic [21:0] pin_sync; // Second stage, the only one logic reads
	wire [21:0] pin_raw = {BUS_CONFIG_MODE_PIN, PORT_A_INPUT_BOOST_STRAP,
		PORT_B_INPUT_BOOST_STRAP, HOST_INPUT_BOOST_STRAP,
		PORT_A_OUTPUT_EMPH_STRAP, PORT_B_OUTPUT_EMPH_STRAP,
		HOST_OUTPUT_EMPH_STRAP, RATE_STRAP, IDLE_CONTROL_STRAPS,
		BROADCAST_ENABLE, LANE0_PATH_SELECT, LANE1_PATH_SELECT,
		DETECTED_6G, BUS_CLOCK_IN};
	always_ff @(posedge CLOCK) begin
		pin_meta <= pin_raw;
		pin_sync <= pin_meta;
	end

	// Synchronised pin names
	// Field positions follow the concatenation order above, top bit first
	wire bus_mode = pin_sync[21]; // High selects register control
	wire [1:0] s_boost_a = pin_sync[20:19];
	wire [1:0] s_boost_b = pin_sync[18:17];
	wire [1:0] s_boost_h = pin_sync[16:15];
	wire [1:0] s_emph_a = pin_sync[14:13];
	wire [1:0] s_emph_b = pin_sync[12:11];
	wire [1:0] s_emph_h = pin_sync[10:9];
	wire [1:0] s_rate = pin_sync[8:7];
	wire [1:0] s_idle = pin_sync[6:5];
	wire pin_bcast = pin_sync[4];
	wire pin_lane0_path_select = pin_sync[3];
	wire pin_lane1_path_select = pin_sync[2];
	wire det_6g = pin_sync[1];
	wire bus_clk = pin_sync[0];

	// Three-level decode: {high, not low}; 01 means floating
	function automatic level_e lvl(input logic [1:0] p);
		if (p == 2'h3) begin
			lvl = LVL_HIGH;
		end else if (p == 2'h1) begin
			lvl = LVL_FLOAT;
		end else begin
			lvl = LVL_LOW;
		end
	endfunction : lvl

	// Boost decode
	function automatic boost_e boost_of(input level_e l);
		unique case (l)
			LVL_LOW: boost_of = BOOST_9DB;
			LVL_FLOAT: boost_of = BOOST_13P5DB;
			default: boost_of = BOOST_18P4DB;
		endcase
	endfunction : boost_of

	// Emphasis decode, pulse width from the effective rate
	// Any active emphasis lifts the swing: the plain levels to 1000 mV,
	// the enhanced two-bit level to 1200 mV. The boost and idle choices
	// are passed through so that one call builds a whole side setting.
	function automatic lane_cfg_s emph_of(input level_e l, input logic fast,
		input boost_e b, input idle_e i);
		lane_cfg_s c;
		c.boost = b;
		c.idle = i;
		unique case (l)
			LVL_LOW: begin
				c.emph = EMPH_3P5DB;
				c.swing = SWING_1000MV;
				c.pulse = fast ? PW_200PS : PW_330PS;
			end
			LVL_HIGH: begin
				c.emph = EMPH_6DB;
				c.swing = SWING_1000MV;
				c.pulse = fast ? PW_200PS : PW_330PS;
			end
			default: begin
				c.emph = fast ? EMPH_12DB : EMPH_9DB;
				c.swing = SWING_1200MV;
				c.pulse = fast ? PW_160PS : PW_250PS;
			end
		endcase
		emph_of = c;
	endfunction : emph_of

	// Rate: low 3G, high 6G, floating follows detector
	wire level_e rate_lvl = lvl(s_rate);
	wire rate_fast = (rate_lvl == LVL_HIGH) ||
		((rate_lvl == LVL_FLOAT) && det_6g);

	// Idle strap decode
	wire level_e idle_lvl = lvl(s_idle);
	wire idle_e pin_idle = (idle_lvl == LVL_LOW) ? IDLE_PASS :
		(idle_lvl == LVL_HIGH) ? IDLE_FORCE : IDLE_AUTO;

	// Strap-mode settings, one per side
	wire lane_cfg_s strap_a = emph_of(lvl(s_emph_a), rate_fast,
		boost_of(lvl(s_boost_a)), pin_idle);
	wire lane_cfg_s strap_b = emph_of(lvl(s_emph_b), rate_fast,
		boost_of(lvl(s_boost_b)), pin_idle);
	wire lane_cfg_s strap_h = emph_of(lvl(s_emph_h), rate_fast,
		boost_of(lvl(s_boost_h)), pin_idle);

	// Bus mode edge tracking and soft reset
	logic mode_prev;
	logic soft_reset;
	wire reg_clear = !bus_mode || soft_reset;

	// Registers: control, and six lane words, four lane ends and two spare
	logic [7:0] ctrl;
	logic [7:0] lane_reg [0:5];
	logic ctrl_written; // Pin override records for control pins
	logic [5:0] lane_written;

	// Wishbone decode
	// A request is taken only while ack is low, so each cycle is taken
	// once and the registered ack drops in the cycle after it was given.
	// Only byte lane 0 carries register bits; other lanes are ignored.
	wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
	wire sel_ctrl = (WB_ADR_I == `REG_CTRL);
	// Lane words are contiguous: index 0 port A, 1 port B, 2 host lane 0,
	// 3 host lane 1, 4 and 5 spare. Status and address lie above them.
	wire [2:0] lane_idx = 3'(WB_ADR_I[7:2] - 6'h1);
	wire sel_lane = (WB_ADR_I[1:0] == 2'h0) && (WB_ADR_I >= `REG_LANE0) &&
		(WB_ADR_I <= 8'h18);
	wire sel_status = (WB_ADR_I == `REG_STATUS);

	// Control register: written only in bus mode
	always_ff @(posedge CLOCK) begin
		if (!RST_N || reg_clear) begin
			ctrl <= `CTRL_RESET;
			ctrl_written <= 1'b0;
		end else if (wb_wr && sel_ctrl) begin
			ctrl <= WB_DAT_I[7:0];
			ctrl_written <= 1'b1;
		end
	end

	// Soft reset pulse from control bit zero
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			soft_reset <= 1'b0;
			mode_prev <= 1'b0;
		end else begin
			soft_reset <= wb_wr && sel_ctrl && WB_DAT_I[`CTRL_SOFT_RESET];
			mode_prev <= bus_mode;
		end
	end

	// Lane registers, one generate entry each
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_lane
			wire hit = wb_wr && sel_lane && (lane_idx == 3'(g));
			always_ff @(posedge CLOCK) begin
				if (!RST_N || reg_clear) begin
					lane_reg[g] <= `LANE_RESET;
					lane_written[g] <= 1'b0;
				end else if (hit) begin
					lane_reg[g] <= WB_DAT_I[7:0];
					lane_written[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// Register lane word to settings
	// Register control has no rate table, so the pulse width stays at the
	// slow entry; software sets swing and emphasis codes directly.
	// Until a lane word is written its idle field defers to the idle pin.
	function automatic lane_cfg_s reg_cfg(input logic [7:0] r, input idle_e pi,
		input logic use_pin);
		lane_cfg_s c;
		c.boost = boost_e'(r[`LANE_BOOST_LO +: 2]);
		c.emph = emph_e'({1'b0, r[`LANE_EMPH_LO +: 2]});
		c.pulse = PW_330PS;
		c.swing = swing_e'(r[`LANE_SWING_LO +: 2]);
		c.idle = use_pin ? pi : idle_e'(r[`LANE_IDLE_LO +: 2]);
		reg_cfg = c;
	endfunction : reg_cfg

	// Per-lane register settings; idle pin rules until lane written
	lane_cfg_s reg_lane [0:5];
	generate
		for (g = 0; g < 6; g++) begin : g_cfg
			assign reg_lane[g] = reg_cfg(lane_reg[g], pin_idle, !lane_written[g]);
		end
	endgenerate

	// Mode switch takes effect in the same cycle the pin is seen
	assign PORT_A_CFG = bus_mode ? reg_lane[0] : strap_a;
	assign PORT_B_CFG = bus_mode ? reg_lane[1] : strap_b;
	assign HOST_LANE_CFG[0] = bus_mode ? reg_lane[2] : strap_h;
	assign HOST_LANE_CFG[1] = bus_mode ? reg_lane[3] : strap_h;

	// Address straps: four low bits from boost/emph A/B pins
	wire [3:0] addr_sel = {s_emph_b[1], s_emph_a[1], s_boost_b[1],
		s_boost_a[1]};
	assign SLAVE_ADDRESS = bus_mode ? {3'h5, addr_sel} : 7'h50;

	// Path selects: pins unless the control register was written
	wire lane0_path_select = ctrl_written ? ctrl[`CTRL_PATH0] : pin_lane0_path_select;
	wire lane1_path_select = ctrl_written ? ctrl[`CTRL_PATH1] : pin_lane1_path_select;
	wire bcast = ctrl_written ? ctrl[`CTRL_BCAST] : pin_bcast;
	wire [1:0] sel = {lane1_path_select, lane0_path_select};
	wire [1:0] force_idle = {2{PORT_A_CFG.idle == IDLE_FORCE}};

	// Data path routing per lane
	// The host output always takes the selected port; the host input feeds
	// the selected port, or both ports when broadcast is on. An output that
	// is not fed is muted to zero, which the analog stage turns into idle.
	// Forced idle or a detected idle input mutes every output of the lane.
	generate
		for (g = 0; g < 2; g++) begin : g_path
			wire auto_mute = (pin_idle == IDLE_AUTO) &&
				INPUT_BELOW_THRESHOLD[g];
			wire mute = force_idle[g] || auto_mute;
			assign HOST_OUT_LANE[g] = mute ? 1'b0 :
				(sel[g] ? PORT_A_IN_LANE[g] : PORT_B_IN_LANE[g]);
			assign PORT_A_OUT_LANE[g] = (!mute && (sel[g] || bcast)) ?
				HOST_IN_LANE[g] : 1'b0;
			assign PORT_B_OUT_LANE[g] = (!mute && (!sel[g] || bcast)) ?
				HOST_IN_LANE[g] : 1'b0;
		end
	endgenerate

	// Bus clock low timeout counter
	// Counts while the synchronised bus clock is low in bus mode; any high
	// level restarts it. The flag stands until the clock goes high again or bus mode drops.
	// The count is held at its end so the flag cannot wrap and drop.
	logic [20:0] low_cnt;
	always_ff @(posedge CLOCK) begin
		if (!RST_N || bus_clk || !bus_mode) begin
			low_cnt <= 21'h0;
			BUS_TIMEOUT <= 1'b0;
		end else if (low_cnt == 21'(`TIMEOUT_CYC - 1)) begin
			BUS_TIMEOUT <= 1'b1;
		end else begin
			low_cnt <= low_cnt + 21'h1;
		end
	end

	// Ready after power-on delay; no clock stretching is done
	// The delay is cut well short of the limit, so the block is ready long
	// before a host may address it; ready then stands until reset.
	logic [24:0] por_cnt;
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			por_cnt <= 25'h0;
			BUS_READY <= 1'b0;
		end else if (por_cnt == 25'(`POR_CYC / 1000)) begin
			BUS_READY <= 1'b1;
		end else begin
			por_cnt <= por_cnt + 25'h1;
		end
	end

	// Read data mux
	wire [7:0] status = {3'h0, rate_fast, bcast, lane1_path_select, lane0_path_select, bus_mode};
	wire [7:0] rd = sel_ctrl ? ctrl : sel_status ? status :
		sel_lane ? lane_reg[lane_idx] :
		(WB_ADR_I == `REG_ADDR) ? {1'b0, SLAVE_ADDRESS} : 8'h00;

	// Wishbone answer one cycle after the request
	// Read data is captured with the ack and stands through the ack cycle;
	// the master takes it at the edge at which it samples ack high.
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= {24'h0, rd};
		end
	end

endmodule : lane_path_select_and_config_decode
`default_nettype wire
